// ==== design/adc_conversion_control.sv ====
// control logic of a 10-bit successive-approximation converter
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       ARST_N_I,
  // register port
  input  wire logic [2:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // trigger flags from other peripherals
  input  wire logic [6:0] TRIG_I,
  // analog core
  input  wire logic [9:0] CORE_RESULT_I,
  output logic            CORE_ENABLE_O,
  output logic            CORE_TICK_O,
  output logic            CORE_START_O,
  output logic      [5:0] CORE_CHANNEL_O,
  output logic      [1:0] CORE_REF_O,
  output logic      [1:0] CORE_GAIN_O
);

  // least divide that keeps the converter clock within full resolution;
  // faster codes still run, software only sees the warning bit
  localparam logic [8:0] DIV_MIN = 9'(`DIV_MIN_FULL_RES);

  // the first conversion out of reset is a long one as well, even when
  // software switches on at the very first edge after reset
  localparam ctrl_state_type RESET_STATE = '{
    state:      IDLE,
    power_gate: `RST_POWER_GATE,
    first_conv: 1'b1,
    default:    '0
  };

  ctrl_state_type s_reg;
  ctrl_state_type s_next;
  prescale_if     pif ();

  logic       on_eff;
  logic       wr_ctrl_a;
  logic       wr_ctrl_b;
  logic       wr_chan;
  logic       wr_power;
  logic       go_req;
  logic       trig_level;
  logic       trig_edge;
  logic       trig_start;
  logic       done_evt;
  logic       free_run;
  logic [4:0] last_tick;
  logic [7:0] low_byte;
  logic [7:0] high_byte;
  logic       rate_warn;
  gain_type   gain;
  logic       rd_low;
  logic       on_bit_next;
  logic       power_next;
  logic       on_next;

  ////////////////////////////////////////////////////////////////////////////
  // prescaler: runs only while on, restarted by an auto trigger
  assign pif.enable  = on_eff;
  assign pif.restart = trig_start;
  assign pif.div_sel = s_reg.div_sel;

  adc_prescaler u_prescaler (
    .clk_i    (CORE_CLK_I),
    .arst_n_i (ARST_N_I),
    .pif      (pif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decodes of the register port and the control bits
  assign on_eff    = s_reg.on_bit && !s_reg.power_gate;
  assign wr_ctrl_a = WR_I && (ADDR_I == `OFS_CTRL_A);
  assign wr_ctrl_b = WR_I && (ADDR_I == `OFS_CTRL_B);
  assign wr_chan   = WR_I && (ADDR_I == `OFS_CHAN_SEL);
  assign wr_power  = WR_I && (ADDR_I == `OFS_POWER);
  assign go_req    = wr_ctrl_a && WDATA_I[`BIT_GO];
  assign free_run  = s_reg.auto_on && (s_reg.src_sel == 3'h0);
  assign rate_warn = divide_of(s_reg.div_sel) < DIV_MIN;

  ////////////////////////////////////////////////////////////////////////////
  // on state as it will stand after this cycle's writes: a go written
  // together with the on bit must still start, and a switch-off must
  // cancel a start pulse that the same edge would otherwise launch
  assign on_bit_next = wr_ctrl_a ? WDATA_I[`BIT_ON] : s_reg.on_bit;
  assign power_next  = wr_power ? WDATA_I[`BIT_POWER_GATE] : s_reg.power_gate;
  assign on_next     = on_bit_next && !power_next;

  // a low-byte read in the completion cycle locks at once, so the high
  // byte can never come from a newer conversion than the low byte
  assign rd_low = RD_I && (ADDR_I == `OFS_RESULT_LOW);

  // source 0 is the done flag, handled at completion; others are flags
  // taken as plain levels, whatever their own interrupt enables say
  always_comb begin
    if (s_reg.src_sel == 3'h0) begin
      trig_level = 1'b0;
    end else begin
      trig_level = s_reg.trig_sync[3'(s_reg.src_sel - 3'h1)];
    end
  end

  // only a fresh edge counts; a level still high starts nothing
  assign trig_edge  = trig_level && !s_reg.trig_prev;
  assign trig_start = s_reg.auto_on && on_eff && trig_edge &&
                      (s_reg.state == IDLE);

  // conversion length, long for the first one after enable
  assign last_tick = s_reg.conv_long ? (`CONV_TICKS_FIRST - 5'd1) :
                                       (`CONV_TICKS_NORMAL - 5'd1);
  assign done_evt  = (s_reg.state == CONVERT) && pif.tick &&
                     (s_reg.cnt == last_tick);

  ////////////////////////////////////////////////////////////////////////////
  // result byte formats
  always_comb begin
    if (s_reg.left_align) begin
      high_byte = s_reg.result[9:2];
      low_byte  = {s_reg.result[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, s_reg.result[9:8]};
      low_byte  = s_reg.result[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // gain decode of the applied channel: bits 4:3 pick the group,
  // single-ended codes leave the amplifier out entirely
  always_comb begin
    unique case (s_reg.app_chan[4:3])
      2'b01: begin
        gain = s_reg.app_chan[0] ? GAIN_X200 : GAIN_X10;
      end
      2'b10: begin
        gain = GAIN_UNITY;
      end
      2'b00,
      2'b11: begin
        gain = GAIN_BYPASS;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state of the whole block
  always_comb begin
    s_next             = s_reg;
    s_next.start_pulse = 1'b0;
    s_next.rdata       = 8'h00;

    // trigger pins pass two flops before any logic reads them
    s_next.trig_meta = TRIG_I;
    s_next.trig_sync = s_reg.trig_meta;
    s_next.trig_prev = trig_level;

    // register writes
    if (wr_ctrl_a) begin
      s_next.on_bit  = WDATA_I[`BIT_ON];
      s_next.auto_on = WDATA_I[`BIT_AUTO];
      s_next.div_sel = WDATA_I[`FLD_DIV];
      if (WDATA_I[`BIT_DONE]) begin
        s_next.done_flag = 1'b0;
      end
    end
    if (wr_ctrl_b) begin
      s_next.src_sel = WDATA_I[`FLD_TRIG];
      s_next.chan[5] = WDATA_I[`BIT_CHAN_HI];
    end
    if (wr_chan) begin
      s_next.ref_sel    = WDATA_I[`FLD_REF];
      s_next.left_align = WDATA_I[`BIT_LEFT];
      s_next.chan[4:0]  = WDATA_I[`FLD_CHAN_LO];
    end
    if (wr_power) begin
      s_next.power_gate = WDATA_I[`BIT_POWER_GATE];
    end

    // register reads, data stand in the next cycle only
    if (RD_I) begin
      unique case (ADDR_I)
        `OFS_RESULT_LOW: begin
          s_next.rdata = low_byte;
          s_next.lock  = 1'b1;
        end
        `OFS_RESULT_HIGH: begin
          s_next.rdata = high_byte;
          s_next.lock  = 1'b0;
        end
        `OFS_CTRL_A: begin
          s_next.rdata = {s_reg.on_bit, (s_reg.state != IDLE), s_reg.auto_on,
                          s_reg.done_flag, 1'b0, s_reg.div_sel};
        end
        `OFS_CTRL_B: begin
          s_next.rdata = {rate_warn, 3'h0, s_reg.chan[5], s_reg.src_sel};
        end
        `OFS_CHAN_SEL: begin
          s_next.rdata = {s_reg.ref_sel, s_reg.left_align, s_reg.chan[4:0]};
        end
        `OFS_POWER: begin
          s_next.rdata = {7'h00, s_reg.power_gate};
        end
        default: begin
          s_next.rdata = 8'h00;
        end
      endcase
    end

    // selections follow the register except while a conversion runs,
    // and only reach the core once the converter is on
    if (on_eff && ((s_reg.state != CONVERT) || done_evt)) begin
      s_next.app_chan = s_reg.chan;
      s_next.app_ref  = s_reg.ref_sel;
    end

    // conversion sequencer
    unique case (s_reg.state)
      IDLE: begin
        // trig_start already needs the converter on; a go needs it on after
        // this write, so on and go may be written in one go
        if ((on_next && go_req) || trig_start) begin
          s_next.state = WAIT_TICK;
        end
      end
      WAIT_TICK: begin
        if (pif.tick) begin
          s_next.state       = CONVERT;
          s_next.cnt         = 5'd0;
          s_next.start_pulse = 1'b1;
          s_next.conv_long   = s_reg.first_conv;
          s_next.first_conv  = 1'b0;
        end
      end
      CONVERT: begin
        if (done_evt) begin
          // flag sets even when the result is dropped; set beats a clear
          s_next.done_flag = 1'b1;
          if (!s_reg.lock && !rd_low) begin
            s_next.result = CORE_RESULT_I;
          end
          if (free_run) begin
            // next conversion starts at once, done flag cleared or not
            s_next.cnt         = 5'd0;
            s_next.start_pulse = 1'b1;
            s_next.conv_long   = 1'b0;
          end else begin
            s_next.state = IDLE;
          end
        end else if (pif.tick) begin
          s_next.cnt = s_reg.cnt + 5'd1;
        end
      end
    endcase

    // switching off aborts any conversion and arms the long first one;
    // taken from the next on state so no start leaves at the off edge
    if (!on_next) begin
      s_next.state       = IDLE;
      s_next.cnt         = 5'd0;
      s_next.start_pulse = 1'b0;
      s_next.first_conv  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the one state register
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_reg <= RESET_STATE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign RDATA_O        = s_reg.rdata;
  assign CORE_ENABLE_O  = on_eff;
  assign CORE_TICK_O    = pif.tick;
  assign CORE_START_O   = s_reg.start_pulse;
  assign CORE_CHANNEL_O = s_reg.app_chan;
  assign CORE_REF_O     = s_reg.app_ref;
  assign CORE_GAIN_O    = gain;

endmodule // adc_conversion_control

// ==== shared/adc_ctrl_regs.svh ====
// register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// register offsets on the byte-wide register port
`define OFS_RESULT_LOW  3'h0
`define OFS_RESULT_HIGH 3'h1
`define OFS_CTRL_A      3'h2
`define OFS_CTRL_B      3'h3
`define OFS_CHAN_SEL    3'h4
`define OFS_POWER       3'h5

// converter_ctrl_a fields
`define BIT_ON          7
`define BIT_GO          6
`define BIT_AUTO        5
`define BIT_DONE        4
`define FLD_DIV         2:0

// converter_ctrl_b fields
`define BIT_RATE_WARN   7
`define BIT_CHAN_HI     3
`define FLD_TRIG        2:0

// channel_select_reg fields
`define FLD_REF         7:6
`define BIT_LEFT        5
`define FLD_CHAN_LO     4:0

// power_reduction_reg fields
`define BIT_POWER_GATE  0

// reset values; every field not named here resets to zero, save the rate warning bit, which reads one
`define RST_POWER_GATE  1'b1

// conversion lengths in converter clock ticks
`define CONV_TICKS_NORMAL 5'd13
`define CONV_TICKS_FIRST  5'd25

// clock rates in kHz and the least divide for full resolution
`define CPU_CLK_KHZ       50000
`define CONV_CLK_MAX_KHZ  200
`define DIV_MIN_FULL_RES  ((`CPU_CLK_KHZ + `CONV_CLK_MAX_KHZ - 1) / `CONV_CLK_MAX_KHZ)

`endif

// ==== shared/adc_ctrl_pkg.sv ====
// types shared by the converter control and its prescaler
package adc_ctrl_pkg;

  // conversion sequencer states
  typedef enum logic [1:0] {
    IDLE,
    WAIT_TICK,
    CONVERT
  } conv_state_type;

  // gain stage setting sent to the analog core
  typedef enum logic [1:0] {
    GAIN_BYPASS,
    GAIN_UNITY,
    GAIN_X10,
    GAIN_X200
  } gain_type;

  // whole state of the control block
  typedef struct packed {
    conv_state_type state;
    logic           on_bit;
    logic           auto_on;
    logic           done_flag;
    logic           left_align;
    logic           power_gate;
    logic           first_conv;
    logic           conv_long;
    logic           lock;
    logic           trig_prev;
    logic           start_pulse;
    logic [2:0]     div_sel;
    logic [2:0]     src_sel;
    logic [5:0]     chan;
    logic [5:0]     app_chan;
    logic [1:0]     ref_sel;
    logic [1:0]     app_ref;
    logic [4:0]     cnt;
    logic [9:0]     result;
    logic [6:0]     trig_meta;
    logic [6:0]     trig_sync;
    logic [7:0]     rdata;
  } ctrl_state_type;

  // whole state of the prescaler
  typedef struct packed {
    logic [7:0] count;
  } presc_state_type;

  // divide ratio of a clock_divide_sel code: 2, 4, 8 ... 256
  function automatic logic [8:0] divide_of(input logic [2:0] sel);
    divide_of = 9'h002 << sel;
  endfunction

endpackage

// ==== shared/prescale_if.sv ====
// link between the control block and its converter clock prescaler
`timescale 1ns/1ns
interface prescale_if;
  logic       enable;
  logic       restart;
  logic [2:0] div_sel;
  logic       tick;

  modport ctrl  (output enable, output restart, output div_sel, input tick);
  modport presc (input enable, input restart, input div_sel, output tick);
endinterface

// ==== design/adc_prescaler.sv ====
// converter clock prescaler: one-cycle tick every divide_of(div_sel) cpu cycles
`timescale 1ns/1ns
module adc_prescaler
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  arst_n_i,
  // control side
  prescale_if.presc  pif
);

  presc_state_type s_reg;
  presc_state_type s_next;
  logic [8:0]      last;

  ////////////////////////////////////////////////////////////////////////////
  // held at zero while off or on restart, so a trigger sees a fixed delay
  always_comb begin
    last   = divide_of(pif.div_sel) - 9'h001;
    s_next = s_reg;
    if (!pif.enable || pif.restart) begin
      s_next.count = 8'h00;
    end else if (pif.tick) begin
      s_next.count = 8'h00;
    end else begin
      s_next.count = s_reg.count + 8'h01;
    end
  end

  // tick in the last cycle of each divide period
  assign pif.tick = pif.enable && !pif.restart && ({1'b0, s_reg.count} == last);

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_reg <= '{count: 8'h00};
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // adc_prescaler

// ==== bench/adc_conversion_control_props.sv ====
// port checker for the converter control, bound to its top module
`timescale 1ns/1ns
module adc_conversion_control_props
  import adc_ctrl_pkg::*;
(
  // clock and reset
  input wire logic       CORE_CLK_I,
  input wire logic       ARST_N_I,
  // analog core side
  input wire logic       CORE_ENABLE_O,
  input wire logic       CORE_TICK_O,
  input wire logic       CORE_START_O,
  input wire logic [5:0] CORE_CHANNEL_O,
  input wire logic [1:0] CORE_REF_O,
  input wire logic [1:0] CORE_GAIN_O
);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  //////////////////////////////////////////////////
  // ticks since the last start; saturates so idle spans never wrap
  logic [4:0] tick_cnt_reg;
  logic       started_reg;
  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tick_cnt_reg <= 5'h00;
      started_reg  <= 1'b0;
    end else if (CORE_START_O) begin
      tick_cnt_reg <= 5'h00;
      started_reg  <= 1'b1;
    end else if (CORE_TICK_O && tick_cnt_reg != 5'h1F) begin
      tick_cnt_reg <= tick_cnt_reg + 5'h01;
    end
  end
  //////////////////////////////////////////////////
  // gain follows the applied channel; single-ended codes bypass
  a_gain_decode: assert property (
    CORE_GAIN_O == ((CORE_CHANNEL_O[4:3] == 2'b01) ? {1'b1, CORE_CHANNEL_O[0]}
                                                   : {1'b0, CORE_CHANNEL_O[4:3] == 2'b10}))
    else $error("gain code does not match applied channel");
  a_tick_spaced: assert property (CORE_TICK_O |=> !CORE_TICK_O)
    else $error("converter tick wider than one cycle");
  a_start_on_tick: assert property (CORE_START_O |-> $past(CORE_TICK_O))
    else $error("start not aligned to a converter tick");
  a_start_enabled: assert property (CORE_START_O |-> CORE_ENABLE_O)
    else $error("start while converter disabled");
  a_chan_frozen: assert property (CORE_START_O |=> $stable(CORE_CHANNEL_O) [*8])
    else $error("channel changed during conversion");
  a_ref_frozen: assert property (CORE_START_O |-> ##2 $stable(CORE_REF_O))
    else $error("reference changed during conversion");
  a_conv_length: assert property (
    CORE_START_O && started_reg |-> tick_cnt_reg >= 5'd13)
    else $error("new start before conversion length ran out");
  a_presc_held: assert property ($rose(CORE_ENABLE_O) |-> !CORE_TICK_O)
    else $error("prescaler ticked at switch on");
  // main scenarios reached
  c_start: cover property (CORE_START_O);
  c_gain_high: cover property (CORE_GAIN_O == 2'h3);
  c_back_start: cover property (CORE_START_O && started_reg);
endmodule // adc_conversion_control_props

bind adc_conversion_control adc_conversion_control_props i_adc_conversion_control_props (
  .CORE_CLK_I(CORE_CLK_I), .ARST_N_I(ARST_N_I), .CORE_ENABLE_O(CORE_ENABLE_O),
  .CORE_TICK_O(CORE_TICK_O), .CORE_START_O(CORE_START_O), .CORE_CHANNEL_O(CORE_CHANNEL_O),
  .CORE_REF_O(CORE_REF_O), .CORE_GAIN_O(CORE_GAIN_O));

// ==== bench/analog_core_model.sv ====
// behavioural analog core: latches a channel-coded value at each start
`timescale 1ns/1ns
module analog_core_model (
  // clock
  input  wire logic       clk_i,
  // control from the converter
  input  wire logic       enable_i,
  input  wire logic       start_i,
  input  wire logic [5:0] channel_i,
  // result
  output logic      [9:0] result_o = 10'h000
);
  // an unpowered core toggles its output so stale data never looks valid
  always @(posedge clk_i) begin
    if (!enable_i) begin
      result_o <= ~result_o;
    end else if (start_i) begin
      result_o <= {channel_i, ~channel_i[3:0]};
    end
  end
endmodule // analog_core_model

// ==== bench/adc_conversion_control_tb.sv ====
// self-checking bench for the converter control
`timescale 1ns/1ns
`include "adc_ctrl_regs.svh"
module adc_conversion_control_tb
  import adc_ctrl_pkg::*;
;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [6:0] trig = 7'h00;
  logic [7:0] rdata, d;
  logic [9:0] core_res;
  logic       core_en, core_tick, core_start;
  logic [5:0] core_chan;
  logic [1:0] core_ref, core_gain;
  logic [4:0] gch [5] = '{5'h08, 5'h09, 5'h10, 5'h00, 5'h18};
  logic [1:0] ggain [5] = '{2'h2, 2'h3, 2'h1, 2'h0, 2'h0};
  int         fails = 0;
  int         n_checks = 0;

  always #10 clk = ~clk;

  adc_conversion_control i_adc_conversion_control (
    .CORE_CLK_I(clk), .ARST_N_I(arst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .TRIG_I(trig), .CORE_RESULT_I(core_res),
    .CORE_ENABLE_O(core_en), .CORE_TICK_O(core_tick), .CORE_START_O(core_start),
    .CORE_CHANNEL_O(core_chan), .CORE_REF_O(core_ref), .CORE_GAIN_O(core_gain));
  analog_core_model i_analog_core_model (
    .clk_i(clk), .enable_i(core_en), .start_i(core_start), .channel_i(core_chan),
    .result_o(core_res));
  //////////////////////////////////////////////////
  // compare and register access helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    rd_reg(a);
    chk(d & m, e);
  endtask
  // bounded poll of one control bit
  task automatic wait_bit(input int b, input logic v);
    for (int i = 0; i < 60; i++) begin
      rd_reg(`OFS_CTRL_A);
      if (d[b] === v) return;
    end
    chk({7'h00, d[b]}, {7'h00, v});
  endtask
  task automatic conv(input logic [7:0] v);
    wr_reg(`OFS_CTRL_A, v);
    wait_bit(`BIT_GO, 1'b0);
  endtask
  task automatic done_test(input string s);
    $display("test %s finished, failures so far %0d", s, fails);
  endtask
  task automatic finish_test;
    $display("checks %0d failures %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////
  // watchdog: whole sequence needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    finish_test();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk(`OFS_CTRL_A, 8'h00);
    rd_chk(`OFS_POWER, 8'h01);
    rd_chk(`OFS_CTRL_B, 8'h80);
    rd_chk(3'h6, 8'h00);
    done_test("reset");
    wr_reg(`OFS_CHAN_SEL, 8'h5A);
    wr_reg(`OFS_POWER, 8'h00);
    @(negedge clk);
    chk({core_ref, core_chan}, 8'h00);
    wr_reg(`OFS_CTRL_A, 8'hC0);
    rd_chk(`OFS_CTRL_A, 8'hC0);
    chk({core_ref, core_chan}, 8'h5A);
    wait_bit(`BIT_GO, 1'b0);
    rd_chk(`OFS_CTRL_A, 8'h90);
    rd_chk(`OFS_RESULT_LOW, 8'hA5);
    rd_chk(`OFS_RESULT_HIGH, 8'h01);
    done_test("single");
    // low read locks; a later result must not land until high is read
    wr_reg(`OFS_CHAN_SEL, 8'h7A);
    conv(8'hD0);
    rd_chk(`OFS_RESULT_LOW, 8'h40);
    wr_reg(`OFS_CHAN_SEL, 8'h65);
    conv(8'hD0);
    rd_chk(`OFS_CTRL_A, 8'h90);
    rd_chk(`OFS_RESULT_HIGH, 8'h69);
    conv(8'hD0);
    rd_chk(`OFS_RESULT_HIGH, 8'h16);
    rd_chk(`OFS_RESULT_LOW, 8'h80);
    rd_chk(`OFS_RESULT_HIGH, 8'h16);
    done_test("lock");
    wr_reg(`OFS_CHAN_SEL, 8'h45);
    wr_reg(`OFS_CTRL_A, 8'hD0);
    repeat (6) @(posedge clk);
    wr_reg(`OFS_CHAN_SEL, 8'h5A);
    @(negedge clk);
    chk({2'h0, core_chan}, 8'h05);
    wait_bit(`BIT_GO, 1'b0);
    rd_chk(`OFS_RESULT_LOW, 8'h5A);
    rd_chk(`OFS_RESULT_HIGH, 8'h00);
    chk({2'h0, core_chan}, 8'h1A);
    done_test("channel");
    for (int i = 0; i < 5; i++) begin
      wr_reg(`OFS_CHAN_SEL, {3'h0, gch[i]});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({6'h00, core_gain}, {6'h00, ggain[i]});
    end
    done_test("gain");
    // trigger source 1 is flag bit 0; bit 1 must be ignored
    wr_reg(`OFS_CTRL_B, 8'h01);
    wr_reg(`OFS_CTRL_A, 8'hF0);
    rd_chk(`OFS_CTRL_A, 8'h40, 8'h40);
    wait_bit(`BIT_GO, 1'b0);
    @(posedge clk) trig <= 7'h02;
    repeat (10) @(posedge clk);
    rd_chk(`OFS_CTRL_A, 8'h00, 8'h40);
    @(posedge clk) trig <= 7'h03;
    repeat (6) @(posedge clk);
    rd_chk(`OFS_CTRL_A, 8'h40, 8'h40);
    @(posedge clk) trig <= 7'h02;
    repeat (3) @(posedge clk);
    trig <= 7'h03;
    wait_bit(`BIT_GO, 1'b0);
    repeat (40) @(posedge clk);
    rd_chk(`OFS_CTRL_A, 8'h00, 8'h40);
    @(posedge clk) trig <= 7'h00;
    repeat (4) @(posedge clk);
    trig <= 7'h01;
    wait_bit(`BIT_GO, 1'b1);
    wait_bit(`BIT_GO, 1'b0);
    done_test("trigger");
    // free run keeps going with the done flag left set
    wr_reg(`OFS_CTRL_A, 8'h90);
    wr_reg(`OFS_CTRL_B, 8'h00);
    wr_reg(`OFS_CTRL_A, 8'hF0);
    wait_bit(`BIT_DONE, 1'b1);
    rd_chk(`OFS_CTRL_A, 8'h50, 8'h50);
    repeat (60) @(posedge clk);
    rd_chk(`OFS_CTRL_A, 8'h50, 8'h50);
    conv(8'h90);
    done_test("freerun");
    finish_test();
  end
endmodule // adc_conversion_control_tb
